// ---- common/see_cfg.svh ----
// Constants of the serial EEPROM slave and its bus master
// How it works
// [RQ1] All bytes travel most significant bit first
// [RQ2] First byte is opcode, carrying top address bit
// [RQ3] Unknown opcode: ignore input, output off until reselect
// [RQ4] Deselected: ignore input, output off
// [RQ5] Pause pin changes only while clock low
// [RQ6] Guard pin low inhibits and aborts pending writes
// [RQ7] Set, clear latch and read state opcodes
// [RQ8] Write state, array read, array write opcodes
// [RQ9] Latch clear at start; set it first
// [RQ10] Clear-latch opcode works whatever the guard pin
// [RQ11] Busy bit 0, latch bit 1, protect bits 3:2
// [RQ12] Bits 6:4 zero idle; all ones while busy
// [RQ13] Protect levels: none, top quarter, half, all
// [RQ14] Protect bits written like array, timed cycle
// [RQ15] Read: opcode, address, then data shifted out
// [RQ16] Reads increment address and wrap to zero
// [RQ17] Write needs guard high, latch, unprotected address
// [RQ18] While busy only state read is accepted
// [RQ19] Chip select rises after last bit, starts programming
// [RQ20] Page writes wrap on three low address bits
// [RQ21] Latch cleared when write cycle completes
// [RQ22] Disallowed write discarded, standby at select rise
// [RQ23] Select rising mid-byte discards the write
// [RQ24] Write cycle length is a parameterised counter
`ifndef SEE_CFG_SVH
`define SEE_CFG_SVH

`define SEE_ADDR_W      9
`define SEE_PAGE_W      3
`define SEE_CLK_MHZ     50
`define SEE_TWC_US      5000
`define SEE_SCK_HALF    8

`define SEE_OP_SETL     3'h6
`define SEE_OP_CLRL     3'h4
`define SEE_OP_RDST     3'h5
`define SEE_OP_WRST     3'h1
`define SEE_OP_READ     3'h3
`define SEE_OP_WRITE    3'h2
`define SEE_OP_HI       4'h0
`define SEE_OP_A8_BIT   3

`define SEE_ST_BUSY     0
`define SEE_ST_WEL      1
`define SEE_ST_BP_LO    2
`define SEE_ST_BP_HI    3
`define SEE_ST_BUSY_VAL 8'hFF

`define SEE_REG_TX      2'h0
`define SEE_REG_RX      2'h1
`define SEE_REG_CTRL    2'h2
`define SEE_REG_STAT    2'h3
`define SEE_CTRL_END    0
`define SEE_CTRL_WP     1
`define SEE_CTRL_HOLD   2

`endif

// ---- common/see_if.sv ----
// Link wires between the bus master and the EEPROM slave
`timescale 1ns/1ps
interface see_if;
	logic sck;
	logic cs_n;
	logic si;
	logic hold_n;
	logic wp_n;
	logic so_d;
	logic so_oe_n;
	wire  so;

	// Pull-up keeps the released line at a known level
	assign so = so_oe_n ? 1'b1 : so_d;

	modport dev (input sck, input cs_n, input si, input hold_n, input wp_n, output so_d, output so_oe_n);
	modport host (output sck, output cs_n, output si, output hold_n, output wp_n, input so);
endinterface

// ---- common/see_pkg.sv ----
// Types for the serial EEPROM slave end
package see_pkg;
	typedef enum logic [7:0] {
		SEE_IDLE  = 8'h01,
		SEE_OPC   = 8'h02,
		SEE_ADR   = 8'h04,
		SEE_RDAT  = 8'h08,
		SEE_RSTA  = 8'h10,
		SEE_WDAT  = 8'h20,
		SEE_WSTA  = 8'h40,
		SEE_IGN   = 8'h80
	} see_state_t;

	typedef enum logic [6:0] {
		SEE_K_BAD   = 7'h01,
		SEE_K_SETL  = 7'h02,
		SEE_K_CLRL  = 7'h04,
		SEE_K_RDST  = 7'h08,
		SEE_K_WRST  = 7'h10,
		SEE_K_READ  = 7'h20,
		SEE_K_WRITE = 7'h40
	} see_kind_t;
endpackage

// ---- logic/see_dev.sv ----
// Serial EEPROM slave end: command decode, state byte, protection and array
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "see_cfg.svh"
module see_dev #(
	parameter int ADDR_W       = `SEE_ADDR_W,
	parameter int PAGE_W       = `SEE_PAGE_W,
	parameter int WRITE_CYCLES = `SEE_TWC_US * `SEE_CLK_MHZ
) (
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       reset_n_i,
	// Link
	see_if.dev              link,
	// State for the user side
	output logic            busy_o,
	output logic [7:0]      state_byte_o
);
	localparam int DEPTH = 1 << ADDR_W;
	localparam int PAGE  = 1 << PAGE_W;

	function automatic see_pkg::see_kind_t op_kind(input logic [7:0] b);
		op_kind = see_pkg::SEE_K_BAD;
		if (b[7:4] == `SEE_OP_HI) begin
			case (b[2:0])
				`SEE_OP_SETL:  op_kind = see_pkg::SEE_K_SETL;
				`SEE_OP_CLRL:  op_kind = see_pkg::SEE_K_CLRL;
				`SEE_OP_RDST:  op_kind = see_pkg::SEE_K_RDST;
				`SEE_OP_WRST:  op_kind = see_pkg::SEE_K_WRST;
				`SEE_OP_READ:  op_kind = see_pkg::SEE_K_READ;
				`SEE_OP_WRITE: op_kind = see_pkg::SEE_K_WRITE;
				default:       op_kind = see_pkg::SEE_K_BAD;
			endcase
		end
	endfunction

	function automatic logic protected_at(input logic [ADDR_W-1:0] a, input logic [1:0] lvl);
		case (lvl)
			2'h1:    protected_at = &a[ADDR_W-1:ADDR_W-2];
			2'h2:    protected_at = a[ADDR_W-1];
			2'h3:    protected_at = 1'b1;
			default: protected_at = 1'b0;
		endcase
	endfunction

	logic [4:0]             pins_s;
	logic                   sck_s, cs_n_s, si_s, hold_n_s, wp_n_s;
	logic                   sck_q, cs_q, paused;
	logic                   rise, fall, cs_fall, cs_rise, byte_done;
	logic [7:0]             rx_byte, sh, tx, st_new;
	logic [2:0]             bitcnt, txcnt;
	logic                   tx_on, is_wr, got_byte, wr_abort;
	logic                   wel, busy, busy_done, prog_go;
	logic [1:0]             bp;
	logic [31:0]            wcnt;
	logic [ADDR_W-1:0]      addr;
	logic [7:0]             pbuf [PAGE];
	logic [PAGE-1:0]        pvalid;
	logic [7:0]             mem [DEPTH];
	logic [7:0]             status;
	see_pkg::see_state_t    state;
	see_pkg::see_kind_t     kind;

	see_sync #(.W(5), .RST_VAL(5'h0F)) u_sync (
		.core_clk_i (core_clk_i),
		.reset_n_i  (reset_n_i),
		.d_i        ({link.sck, link.cs_n, link.si, link.hold_n, link.wp_n}),
		.q_o        (pins_s)
	);
	assign {sck_s, cs_n_s, si_s, hold_n_s, wp_n_s} = pins_s;

	// Edges are only seen while selected and not paused
	assign rise      = sck_s & ~sck_q & ~cs_n_s & ~paused; // RQ4 RQ5
	assign fall      = ~sck_s & sck_q & ~cs_n_s & ~paused;
	assign cs_fall   = ~cs_n_s & cs_q;
	assign cs_rise   = cs_n_s & ~cs_q;
	assign rx_byte   = {sh[6:0], si_s}; // RQ1
	assign byte_done = rise && bitcnt == 3'h7;
	assign kind      = op_kind(rx_byte);
	assign busy_done = busy && wcnt == 32'h0;
	assign status    = busy ? `SEE_ST_BUSY_VAL : {4'h0, bp, wel, 1'b0}; // RQ11 RQ12

	// Programming only from a clean byte boundary with everything still allowed
	assign prog_go = cs_rise && !busy && got_byte && bitcnt == 3'h0 && !wr_abort && wel && wp_n_s
		&& (state == see_pkg::SEE_WSTA || (state == see_pkg::SEE_WDAT && |pvalid)); // RQ17 RQ19 RQ23

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sck_q <= 1'b0;
			cs_q  <= 1'b1;
		end else begin
			sck_q <= sck_s;
			cs_q  <= cs_n_s;
		end
	end

	// Pause is taken only with the clock low, and released with the clock low or at deselect
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			paused <= 1'b0;
		end else if (cs_n_s) begin
			paused <= 1'b0;
		end else if (!sck_s) begin
			paused <= ~hold_n_s; // RQ5
		end
	end

	// Receive shifter
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sh     <= 8'h00;
			bitcnt <= 3'h0;
		end else if (cs_fall) begin
			bitcnt <= 3'h0;
		end else if (rise) begin
			sh     <= rx_byte; // RQ1
			bitcnt <= bitcnt + 3'h1;
		end
	end

	// Command sequencer
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= see_pkg::SEE_IDLE;
			is_wr <= 1'b0;
			addr  <= '0;
		end else if (cs_fall) begin
			state <= see_pkg::SEE_OPC; // RQ2
		end else if (cs_n_s) begin
			state <= see_pkg::SEE_IDLE; // RQ4 RQ22
		end else if (byte_done) begin
			case (state)
				see_pkg::SEE_OPC: begin
					is_wr <= kind == see_pkg::SEE_K_WRITE;
					addr[ADDR_W-1] <= rx_byte[`SEE_OP_A8_BIT]; // RQ2 RQ8
					if (busy && kind != see_pkg::SEE_K_RDST) begin
						state <= see_pkg::SEE_IGN; // RQ18
					end else begin
						case (kind)
							see_pkg::SEE_K_RDST:  state <= see_pkg::SEE_RSTA; // RQ7
							see_pkg::SEE_K_READ:  state <= see_pkg::SEE_ADR; // RQ15
							see_pkg::SEE_K_WRST:  state <= (wel && wp_n_s) ? see_pkg::SEE_WSTA : see_pkg::SEE_IGN; // RQ14 RQ22
							see_pkg::SEE_K_WRITE: state <= (wel && wp_n_s) ? see_pkg::SEE_ADR : see_pkg::SEE_IGN; // RQ22
							default:              state <= see_pkg::SEE_IGN; // RQ3
						endcase
					end
				end
				see_pkg::SEE_ADR: begin
					addr[ADDR_W-2:0] <= rx_byte;
					state <= is_wr ? see_pkg::SEE_WDAT : see_pkg::SEE_RDAT; // RQ15
				end
				see_pkg::SEE_WDAT: begin
					addr[PAGE_W-1:0] <= addr[PAGE_W-1:0] + 1'b1; // RQ20
				end
				default: begin
					state <= state;
				end
			endcase
		end else if (fall && state == see_pkg::SEE_RDAT && txcnt == 3'h7) begin
			addr <= addr + 1'b1; // RQ16
		end
	end

	// Transmit shifter, loaded at the address or opcode byte and refilled per byte
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tx        <= 8'h00;
			txcnt     <= 3'h0;
			tx_on     <= 1'b0;
			link.so_d <= 1'b1;
		end else if (cs_fall) begin
			txcnt <= 3'h0;
			tx_on <= 1'b0;
		end else if (byte_done && state == see_pkg::SEE_OPC) begin
			tx <= status;
		end else if (byte_done && state == see_pkg::SEE_ADR) begin
			tx <= mem[{addr[ADDR_W-1], rx_byte}];
		end else if (fall && (state == see_pkg::SEE_RDAT || state == see_pkg::SEE_RSTA)) begin
			link.so_d <= tx[7]; // RQ1
			tx_on     <= 1'b1;
			txcnt     <= txcnt + 3'h1;
			if (txcnt != 3'h7) begin
				tx <= {tx[6:0], 1'b0};
			end else if (state == see_pkg::SEE_RDAT) begin
				tx <= mem[addr + 1'b1]; // RQ16
			end else begin
				tx <= status;
			end
		end
	end

	// Output released when deselected, paused, or outside a read
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			link.so_oe_n <= 1'b1;
		end else begin
			link.so_oe_n <= !(!cs_n_s && !paused && tx_on
				&& (state == see_pkg::SEE_RDAT || state == see_pkg::SEE_RSTA)); // RQ3 RQ4 RQ5
		end
	end

	// Page buffer and write frame bookkeeping
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pvalid   <= '0;
			got_byte <= 1'b0;
			wr_abort <= 1'b0;
			st_new   <= 8'h00;
		end else if (cs_fall) begin
			pvalid   <= '0;
			got_byte <= 1'b0;
			wr_abort <= ~wp_n_s;
		end else begin
			if (!cs_n_s && !wp_n_s) begin
				wr_abort <= 1'b1; // RQ6
			end
			if (byte_done && state == see_pkg::SEE_WDAT) begin
				got_byte <= 1'b1;
				pvalid[addr[PAGE_W-1:0]] <= !protected_at(addr, bp); // RQ13 RQ17
			end
			if (byte_done && state == see_pkg::SEE_WSTA) begin
				got_byte <= 1'b1;
				st_new   <= rx_byte;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (byte_done && state == see_pkg::SEE_WDAT) begin
			pbuf[addr[PAGE_W-1:0]] <= rx_byte; // RQ20
		end
	end

	// Array contents; no reset, as stored data is not control state
	always_ff @(posedge core_clk_i) begin
		if (prog_go && state == see_pkg::SEE_WDAT) begin
			for (int i = 0; i < PAGE; i++) begin
				if (pvalid[i]) begin
					mem[{addr[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= pbuf[i];
				end
			end
		end
	end

	// Write-enable latch
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wel <= 1'b0; // RQ9
		end else if (busy_done) begin
			wel <= 1'b0; // RQ21
		end else if (byte_done && state == see_pkg::SEE_OPC && !busy) begin
			if (kind == see_pkg::SEE_K_CLRL) begin
				wel <= 1'b0; // RQ10
			end else if (kind == see_pkg::SEE_K_SETL && wp_n_s) begin
				wel <= 1'b1; // RQ6 RQ9
			end
		end
	end

	// Self-timed cycle and protect bits
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			busy <= 1'b0;
			wcnt <= 32'h0;
			bp   <= 2'h0;
		end else if (prog_go) begin
			busy <= 1'b1;
			wcnt <= 32'(WRITE_CYCLES - 1); // RQ24
			if (state == see_pkg::SEE_WSTA) begin
				bp <= st_new[`SEE_ST_BP_HI:`SEE_ST_BP_LO]; // RQ14
			end
		end else if (busy_done) begin
			busy <= 1'b0;
		end else if (busy) begin
			wcnt <= wcnt - 32'h1;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			busy_o       <= 1'b0;
			state_byte_o <= 8'h00;
		end else begin
			busy_o       <= busy;
			state_byte_o <= status;
		end
	end
endmodule

// ---- logic/see_host.sv ----
// Bus master end: shifts bytes over the link under register control
`timescale 1ns/1ps
`include "see_cfg.svh"
module see_host #(
	parameter int SCK_HALF = `SEE_SCK_HALF
) (
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       reset_n_i,
	// Register port
	input  wire logic [1:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	// Link
	see_if.host             link
);
	logic       so_s, shifting, hold_req;
	logic [7:0] tx, rx;
	logic [2:0] bitcnt;
	logic [7:0] phase;

	see_sync #(.W(1), .RST_VAL(1'b1)) u_sync (
		.core_clk_i (core_clk_i),
		.reset_n_i  (reset_n_i),
		.d_i        (link.so),
		.q_o        (so_s)
	);

	// Pause pin follows the request only while the clock is low
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hold_req    <= 1'b0;
			link.wp_n   <= 1'b1;
			link.hold_n <= 1'b1;
		end else begin
			if (wr_i && addr_i == `SEE_REG_CTRL) begin
				hold_req  <= wdata_i[`SEE_CTRL_HOLD];
				link.wp_n <= wdata_i[`SEE_CTRL_WP];
			end
			// Never at the edge that raises the clock, so the pin only moves in a low period
			if (!link.sck && !(shifting && link.hold_n && phase == 8'(SCK_HALF - 1))) begin
				link.hold_n <= ~hold_req; // RQ5
			end
		end
	end

	// Byte shifter; the clock idles low so select always rises in a low period
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			link.cs_n <= 1'b1;
			link.sck  <= 1'b0;
			link.si   <= 1'b0;
			shifting  <= 1'b0;
			tx        <= 8'h00;
			rx        <= 8'h00;
			bitcnt    <= 3'h0;
			phase     <= 8'h00;
		end else if (!shifting) begin
			if (wr_i && addr_i == `SEE_REG_TX) begin
				link.cs_n <= 1'b0;
				link.si   <= wdata_i[7]; // RQ1
				tx        <= {wdata_i[6:0], 1'b0};
				shifting  <= 1'b1;
				bitcnt    <= 3'h0;
				phase     <= 8'h00;
			end else if (wr_i && addr_i == `SEE_REG_CTRL && wdata_i[`SEE_CTRL_END]) begin
				link.cs_n <= 1'b1; // RQ19
			end
		end else if (!link.hold_n) begin
			// Paused slave has released its output; restart the low half so it drives again before the rise
			phase <= 8'h00;
		end else if (phase != 8'(SCK_HALF - 1)) begin
			phase <= phase + 8'h01;
		end else begin
			phase    <= 8'h00;
			link.sck <= ~link.sck;
			if (!link.sck) begin
				rx <= {rx[6:0], so_s}; // RQ1 RQ15
			end else begin
				bitcnt  <= bitcnt + 3'h1;
				link.si <= tx[7];
				tx      <= {tx[6:0], 1'b0};
				if (bitcnt == 3'h7) begin
					shifting <= 1'b0;
				end
			end
		end
	end

	// Read data in the cycle after the strobe
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				`SEE_REG_TX:   rdata_o <= tx;
				`SEE_REG_RX:   rdata_o <= rx;
				`SEE_REG_CTRL: rdata_o <= {5'h00, hold_req, link.wp_n, 1'b0};
				default:       rdata_o <= {5'h00, ~link.hold_n, ~link.cs_n, shifting};
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end
endmodule

// ---- logic/see_sync.sv ----
// Two-flop synchroniser for link pins
`timescale 1ns/1ps
module see_sync #(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	// Clock and reset
	input  wire logic         core_clk_i,
	input  wire logic         reset_n_i,
	// Pins
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta;

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta <= RST_VAL;
			q_o  <= RST_VAL;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule

// ---- tb/see_chk.sv ----
// Link checker for the serial EEPROM pair
`timescale 1ns/1ps
module see_chk (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// Link
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic hold_n,
	input wire logic so_d,
	input wire logic so_oe_n
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	// Six cycles leave room for the pin synchroniser lag
	desel_off_a: assert property (cs_n [*6] |-> so_oe_n)
		else $error("so driven while deselected");
	pause_off_a: assert property (!hold_n [*6] |-> so_oe_n)
		else $error("so driven while paused");
	hold_lowclk_a: assert property ($changed(hold_n) |-> !sck)
		else $error("pause pin moved with clock high");
	cs_rise_a: assert property ($rose(cs_n) |-> !sck)
		else $error("select rose with clock high");
	sck_frame_a: assert property ($rose(sck) |-> !cs_n)
		else $error("clock pulse outside frame");
	si_hold_a: assert property (sck && $past(sck) |-> $stable(si))
		else $error("si moved with clock high");
	so_hold_a: assert property (sck && $past(sck) && !so_oe_n |-> $stable(so_d))
		else $error("so moved with clock high");
	sck_high_a: assert property ($rose(sck) |-> sck [*8] ##1 !sck)
		else $error("clock high phase length wrong");
	cover property ($fell(so_oe_n));
	cover property ($fell(hold_n));
	cover property ($rose(cs_n));
endmodule

// ---- tb/tb_spi_serial_eeprom_slave.sv ----
// Self-checking bench joining bus master and EEPROM slave
`timescale 1ns/1ps
module tb_spi_serial_eeprom_slave;
	// Long enough that a status frame and an array read frame land inside the cycle
	localparam int WC = 1000;
	logic       core_clk_i = 1'b0;
	logic       reset_n_i  = 1'b0;
	logic [1:0] addr_i     = 2'h0;
	logic [7:0] wdata_i    = 8'h00;
	logic       wr_i       = 1'b0;
	logic       rd_i       = 1'b0;
	logic [7:0] rdata_o;
	logic       busy_o;
	logic [7:0] state_byte_o;
	logic [7:0] rxb;
	logic       wp         = 1'b1;
	int         n_fail     = 0;
	int         cmp_count  = 0;
	int         seed       = 64102;
	int         mem [512];
	int         wel        = 0;
	int         bp         = 0;

	see_if lnk ();
	see_dev #(.WRITE_CYCLES(WC)) see_dev_inst (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .link(lnk),
		.busy_o(busy_o), .state_byte_o(state_byte_o));
	see_host see_host_inst (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(lnk));
	see_chk see_chk_inst (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .sck(lnk.sck), .cs_n(lnk.cs_n),
		.si(lnk.si), .hold_n(lnk.hold_n), .so_d(lnk.so_d), .so_oe_n(lnk.so_oe_n));

	always #10 core_clk_i = ~core_clk_i;

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic [7:0] est();
		return {4'h0, bp[1:0], wel[0], 1'b0};
	endfunction

	function automatic int prot(input int a);
		return bp == 3 || (bp == 2 && a >= 256) || (bp == 1 && a >= 384);
	endfunction

	task automatic bw(input logic [1:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge core_clk_i);
		wr_i    <= 1'b0;
	endtask

	task automatic br(input logic [1:0] a);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge core_clk_i);
		rd_i   <= 1'b0;
		#1 rxb = rdata_o;
	endtask

	// One byte each way, optionally paused in the first clock low period
	task automatic xb(input logic [7:0] b, input bit p = 1'b0);
		int i;
		bw(2'h0, b);
		if (p) begin
			bw(2'h2, {5'h0, 1'b1, wp, 1'b0});
			repeat (40) @(posedge core_clk_i);
			bw(2'h2, {6'h0, wp, 1'b0});
		end
		for (i = 0; i < 300; i++) begin
			br(2'h3);
			if (rxb[0] === 1'b0)
				break;
		end
		if (i == 300) begin
			n_fail++;
			complete_run();
		end
		br(2'h1);
	endtask

	task automatic ef();
		bw(2'h2, {6'h0, wp, 1'b1});
		repeat (10) @(posedge core_clk_i);
	endtask

	task automatic op1(input logic [7:0] op);
		xb(op);
		ef();
	endtask

	task automatic sl();
		op1(8'h0E);
		wel = wp;
	endtask

	task automatic rs(input logic [7:0] op);
		xb(op);
		xb(8'h00);
		ef();
	endtask

	task automatic sc(input logic [7:0] op);
		rs(op);
		chk(rxb, est());
		chk(state_byte_o, est());
	endtask

	task automatic ww(input int ok);
		int i;
		chk({7'h0, busy_o}, 8'(ok));
		if (ok) begin
			rs(8'h05);
			chk(rxb, 8'hFF);
			xb(8'h03);
			xb(8'h00);
			xb(8'h00);
			chk(rxb, 8'hFF);
			ef();
			for (i = 0; i < 20 && rxb === 8'hFF; i++)
				rs(8'h05);
			if (rxb === 8'hFF) begin
				n_fail++;
				complete_run();
			end
			wel = 0;
		end
		sc(8'h05);
	endtask

	task automatic wf(input logic [8:0] a, input int n);
		int i;
		int ok;
		logic [7:0] d;
		ok = wp && wel && !prot(a) && n > 0;
		xb({4'h0, a[8], 3'h2});
		xb(a[7:0]);
		for (i = 0; i < n; i++) begin
			d = 8'($random(seed));
			xb(d);
			if (ok)
				mem[{a[8:3], 3'(a[2:0] + i)}] = d;
		end
		ef();
		ww(ok);
	endtask

	task automatic rf(input logic [8:0] a, input int n);
		int i;
		xb({4'h0, a[8], 3'h3});
		xb(a[7:0]);
		for (i = 0; i < n; i++) begin
			xb(8'h00, i == 1);
			chk(rxb, mem[(a + i) % 512][7:0]);
		end
		ef();
	endtask

	task automatic ws(input int v);
		sl();
		xb(8'h01);
		xb(8'(v << 2));
		ef();
		bp = v;
		ww(1);
	endtask

	initial begin
		int k;
		int v;
		logic [8:0] pa [3];
		logic [7:0] bad [3];
		pa  = '{9'h000, 9'h100, 9'h180};
		bad = '{8'h07, 8'h00, 8'hA5};
		repeat (12) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		sc(8'h0D);
		wf(9'h000, 1);
		sl();
		sc(8'h05);
		wf(9'h1F8, 10);
		sl();
		wf(9'h000, 8);
		rf(9'h1FC, 8);
		sl();
		wf(9'h010, 0);
		// Guard pin dropped inside an open write frame
		sl();
		xb(8'h02);
		xb(8'h00);
		xb(8'h5A);
		wp = 1'b0;
		bw(2'h2, {6'h0, wp, 1'b0});
		wp = 1'b1;
		ef();
		chk({7'h0, busy_o}, 8'h00);
		sc(8'h05);
		wp = 1'b0;
		bw(2'h2, {6'h0, wp, 1'b0});
		op1(8'h04);
		wel = 0;
		sl();
		wp = 1'b1;
		sc(8'h05);
		for (k = 0; k < 3; k++) begin
			xb(bad[k]);
			xb(8'h05);
			chk(rxb, 8'hFF);
			ef();
		end
		sc(8'h0D);
		for (v = 0; v < 4; v++) begin
			ws(v);
			for (k = 0; k < 3; k++) begin
				sl();
				wf(pa[k], 1);
				rf(pa[k], 1);
			end
		end
		complete_run();
	end
endmodule
